/* File: hw/omn_defines.svh */
// timing counts, opcodes and sizes for the mouse navigation front end
// assumes a 25 MHz core clock; included by the front end design file and the bench
`ifndef OMN_DEFINES_SVH
`define OMN_DEFINES_SVH
`define OMN_CLK_HZ 25000000
`define OMN_DEBOUNCE_MS 15
`define OMN_DEBOUNCE_CYC ((`OMN_CLK_HZ / 1000) * `OMN_DEBOUNCE_MS)
`define OMN_RAD_US 100
`define OMN_RAD_CYC ((`OMN_CLK_HZ / 1000000) * `OMN_RAD_US)
`define OMN_POLL_US 1000
`define OMN_POLL_CYC ((`OMN_CLK_HZ / 1000000) * `OMN_POLL_US)
`define OMN_DETECT_US 1000
`define OMN_DETECT_CYC ((`OMN_CLK_HZ / 1000000) * `OMN_DETECT_US)
`define OMN_SCK_HALF 4
`define OMN_PROG_LEN 1986
`define OMN_PROG_AW 11
`define OMN_ADDR_PROG_BURST 8'h62
`define OMN_ADDR_MOTION_BURST 8'h50
`define OMN_WRITE_BIT 8'h80
`define OMN_MOTION_BYTES 7
`endif

/* File: hw/omn_pkg.sv */
// types shared by the mouse navigation front end
// pairs with omn_defines.svh which holds the numbers
package omn_pkg;
  typedef enum logic [2:0] {
    OMN_IDLE, OMN_ADDR, OMN_WAIT, OMN_DATA, OMN_DONE
  } omn_link_state_t;
  typedef enum logic [1:0] {
    OMN_BOOT, OMN_DOWNLOAD, OMN_RUN
  } omn_phase_t;
  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] dx;
    logic [7:0] dy;
    logic [7:0] surface_quality;
    logic [7:0] shutter_hi;
    logic [7:0] shutter_lo;
    logic [7:0] max_pixel;
  } omn_motion_t;
  typedef struct packed {
    logic left;
    logic wheel;
    logic right;
  } omn_buttons_t;
endpackage

/* File: hw/omn_prog_rom.sv */
// sensor program store, one byte a word, registered read data
// contents loaded by the integrator through the write port before release
`timescale 1ns/1ps
`default_nettype none
module omn_prog_rom #(
  parameter int DEPTH = 1986,
  parameter int AW = 11
) (
  input wire logic clk, // core clock
  input wire logic wr_en, // load strobe
  input wire logic [AW-1:0] wr_addr, // load address
  input wire logic [7:0] wr_data, // load byte
  input wire logic [AW-1:0] rd_addr, // read address
  output logic [7:0] rd_data // byte one cycle after address
);
  logic [7:0] mem [0:DEPTH-1];
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // omn_prog_rom
`default_nettype wire

/* File: hw/omn_nav_frontend.sv */
// mouse navigation front end: serial master to the sensor, wheel decoder,
// button debounce and host-type detection; pins are asynchronous to clk
// Notes on behaviour
// - we always master the serial link and generate its clock.
// - no transfer while sensor sleeps or is held in reset.
// - on writes we drive clock and data out for the whole transfer.
// - reads send address, wait the address delay, then only clock in data.
// - byte transfers; bursts clock many bytes with one address.
// - poll X and Y motion periodically and present them.
// - every change on one wheel phase alone counts one step.
// - direction comes from previous versus current phase pair.
// - buttons low means pressed, high released.
// - buttons debounced about 15 ms before accepting a change.
// - at plug-in detect USB or PS/2 and route the data lines.
// - on USB detection enable the regulator output for the pull-up.
// - download the sensor program by burst after every reset.
`timescale 1ns/1ps
`default_nettype none
`include "omn_defines.svh"
module omn_nav_frontend
  import omn_pkg::*;
#(
  parameter int DEBOUNCE_CYC = `OMN_DEBOUNCE_CYC,
  parameter int RAD_CYC = `OMN_RAD_CYC,
  parameter int POLL_CYC = `OMN_POLL_CYC,
  parameter int DETECT_CYC = `OMN_DETECT_CYC,
  parameter int PROG_LEN = `OMN_PROG_LEN
) (
  input wire logic clk, // 25 MHz core clock
  input wire logic reset_n, // async reset, active low
  input wire logic sensor_sleep_low, // sensor power-down, low = asleep
  input wire logic sensor_reset, // sensor reset, high = held
  output logic chip_select_low, // sensor select, active low
  output logic sclk, // serial clock we generate
  output logic mosi, // serial data to sensor
  output logic mosi_oe, // high while we drive mosi
  input wire logic miso, // serial data from sensor
  input wire logic prog_wr_en, // program store load strobe
  input wire logic [10:0] prog_wr_addr, // program store load address
  input wire logic [7:0] prog_wr_data, // program store load byte
  output logic prog_done, // sensor program downloaded
  output omn_motion_t motion, // last motion burst
  output logic motion_valid, // one-cycle pulse per new burst
  output logic [7:0] wheel_count, // signed wheel position
  input wire logic wheel_a, // wheel phase a
  input wire logic wheel_b, // wheel phase b
  input wire logic left_n, // left button, low = pressed
  input wire logic wheel_btn_n, // wheel button, low = pressed
  input wire logic right_n, // right button, low = pressed
  output omn_buttons_t buttons, // debounced, high = pressed
  input wire logic dminus_in, // host D- level
  input wire logic dplus_in, // host D+ level
  output logic host_is_usb, // detected USB host
  output logic host_detected, // detection finished
  output logic lines_to_engine, // data lines to usb_serial_engine
  output logic regulator_output_pin // pull-up supply enable
);
  // two-flop synchronisers for every pin input
  localparam int NSYNC = 10;
  logic [NSYNC-1:0] sync1, sync2;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {sensor_sleep_low, sensor_reset, miso, wheel_a, wheel_b,
                left_n, wheel_btn_n, right_n, dminus_in, dplus_in};
      sync2 <= sync1;
    end
  end
  logic s_sleep_n, s_srst, s_miso, s_wa, s_wb, s_dm, s_dp;
  logic [2:0] s_btn_n;
  assign {s_sleep_n, s_srst, s_miso, s_wa, s_wb} = sync2[9:5];
  assign s_btn_n = sync2[4:2];
  assign {s_dm, s_dp} = sync2[1:0];

  // link may only run when the sensor is awake and out of reset
  logic link_ok;
  assign link_ok = s_sleep_n && !s_srst;

  // ---------------- serial master ----------------
  omn_phase_t phase;
  omn_link_state_t st;
  logic [2:0] half_cnt;
  logic [2:0] bit_cnt;
  logic [7:0] shreg;
  logic [15:0] wait_cnt;
  logic [10:0] byte_idx;
  logic [19:0] poll_cnt;
  logic [7:0] rom_data;
  logic reading;
  logic tick;
  assign tick = (half_cnt == 3'(`OMN_SCK_HALF - 1));

  omn_prog_rom #(.DEPTH(`OMN_PROG_LEN), .AW(`OMN_PROG_AW)) u_rom (
    .clk(clk),
    .wr_en(prog_wr_en),
    .wr_addr(prog_wr_addr),
    .wr_data(prog_wr_data),
    .rd_addr(byte_idx),
    .rd_data(rom_data)
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      poll_cnt <= '0;
    end else if (st == OMN_IDLE && poll_cnt != 20'(POLL_CYC)) begin
      poll_cnt <= poll_cnt + 20'd1;
    end else if (st != OMN_IDLE) begin
      poll_cnt <= '0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= OMN_BOOT;
      st <= OMN_IDLE;
      half_cnt <= '0;
      bit_cnt <= '0;
      shreg <= '0;
      wait_cnt <= '0;
      byte_idx <= '0;
      reading <= 1'b0;
      chip_select_low <= 1'b1;
      sclk <= 1'b1;
      mosi <= 1'b0;
      mosi_oe <= 1'b0;
      prog_done <= 1'b0;
      motion <= '0;
      motion_valid <= 1'b0;
    end else begin
      motion_valid <= 1'b0;
      unique case (st)
        OMN_IDLE: begin
          sclk <= 1'b1;
          chip_select_low <= 1'b1;
          mosi_oe <= 1'b0;
          half_cnt <= '0;
          if (link_ok && phase == OMN_BOOT) begin
            phase <= OMN_DOWNLOAD;
            shreg <= `OMN_ADDR_PROG_BURST | `OMN_WRITE_BIT;
            reading <= 1'b0;
            byte_idx <= '0;
            st <= OMN_ADDR;
            chip_select_low <= 1'b0;
            mosi_oe <= 1'b1;
          end else if (link_ok && phase == OMN_RUN && poll_cnt == 20'(POLL_CYC)) begin
            shreg <= `OMN_ADDR_MOTION_BURST;
            reading <= 1'b1;
            byte_idx <= '0;
            st <= OMN_ADDR;
            chip_select_low <= 1'b0;
            mosi_oe <= 1'b1;
          end
          bit_cnt <= '0;
        end
        OMN_ADDR, OMN_DATA: begin
          // mode 3: data changes on falling edge, sampled on rising edge
          half_cnt <= tick ? 3'd0 : half_cnt + 3'd1;
          if (tick) begin
            sclk <= ~sclk;
            if (sclk) begin
              mosi <= shreg[7];
            end else begin
              shreg <= {shreg[6:0], s_miso};
              bit_cnt <= bit_cnt + 3'd1;
              if (bit_cnt == 3'd7) begin
                if (st == OMN_ADDR) begin
                  st <= reading ? OMN_WAIT : OMN_DATA;
                  wait_cnt <= '0;
                  if (reading) begin
                    mosi_oe <= 1'b0;
                  end else begin
                    shreg <= rom_data;
                    byte_idx <= byte_idx + 11'd1;
                  end
                end else if (reading) begin
                  unique case (byte_idx[2:0])
                    3'd0: motion.flags <= {shreg[6:0], s_miso};
                    3'd1: motion.dx <= {shreg[6:0], s_miso};
                    3'd2: motion.dy <= {shreg[6:0], s_miso};
                    3'd3: motion.surface_quality <= {shreg[6:0], s_miso};
                    3'd4: motion.shutter_hi <= {shreg[6:0], s_miso};
                    3'd5: motion.shutter_lo <= {shreg[6:0], s_miso};
                    default: motion.max_pixel <= {shreg[6:0], s_miso};
                  endcase
                  byte_idx <= byte_idx + 11'd1;
                  if (byte_idx == 11'(`OMN_MOTION_BYTES - 1)) begin
                    st <= OMN_DONE;
                    motion_valid <= 1'b1;
                  end
                end else begin
                  // program burst: no per-byte address, select held low
                  if (byte_idx == 11'(PROG_LEN)) begin
                    st <= OMN_DONE;
                  end else begin
                    shreg <= rom_data;
                    byte_idx <= byte_idx + 11'd1;
                  end
                end
              end
            end
          end
        end
        OMN_WAIT: begin
          // sensor needs the address delay before it drives miso
          wait_cnt <= wait_cnt + 16'd1;
          if (wait_cnt == 16'(RAD_CYC - 1)) begin
            st <= OMN_DATA;
            half_cnt <= '0;
          end
        end
        OMN_DONE: begin
          mosi_oe <= 1'b0;
          sclk <= 1'b1;
          chip_select_low <= 1'b1;
          if (phase == OMN_DOWNLOAD) begin
            phase <= OMN_RUN;
            prog_done <= 1'b1;
          end
          st <= OMN_IDLE;
        end
        default: st <= OMN_IDLE;
      endcase
      // abort if the sensor sleeps or resets mid transfer
      if (!link_ok && st != OMN_IDLE && st != OMN_DONE) begin
        st <= OMN_IDLE;
        chip_select_low <= 1'b1;
        mosi_oe <= 1'b0;
        sclk <= 1'b1;
        if (phase == OMN_DOWNLOAD) begin
          phase <= OMN_BOOT;
        end
      end
      if (s_srst) begin
        // sensor reset loses its program: download again
        phase <= OMN_BOOT;
        prog_done <= 1'b0;
      end
    end
  end

  // ---------------- wheel quadrature ----------------
  logic [1:0] wheel_prev;
  logic [2:0] wheel_init; // sync chain shows reset zeros for two edges, not the pins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wheel_prev <= '0;
      wheel_init <= '0;
      wheel_count <= '0;
    end else begin
      wheel_prev <= {s_wa, s_wb};
      wheel_init <= {wheel_init[1:0], 1'b1};
      if (wheel_init[2] && wheel_prev != {s_wa, s_wb}) begin
        // gray order 00,01,11,10 is forward; reverse is backward
        if ({wheel_prev[1] ^ s_wb, wheel_prev[0] ^ s_wa} == 2'b10) begin
          wheel_count <= wheel_count + 8'd1;
        end else if ({wheel_prev[1] ^ s_wb, wheel_prev[0] ^ s_wa} == 2'b01) begin
          wheel_count <= wheel_count - 8'd1;
        end
      end
    end
  end

  // ---------------- buttons ----------------
  logic [2:0][19:0] db_cnt;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      db_cnt <= '0;
      buttons <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (buttons[i] == !s_btn_n[i]) begin
          db_cnt[i] <= '0;
        end else if (db_cnt[i] == 20'(DEBOUNCE_CYC - 1)) begin
          buttons[i] <= !s_btn_n[i];
          db_cnt[i] <= '0;
        end else begin
          db_cnt[i] <= db_cnt[i] + 20'd1;
        end
      end
    end
  end

  // ---------------- host detection ----------------
  // PS/2 idles both lines high; USB idle holds D+ and D- low before pull-up
  logic [15:0] det_cnt;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      det_cnt <= '0;
      host_detected <= 1'b0;
      host_is_usb <= 1'b0;
      lines_to_engine <= 1'b0;
      regulator_output_pin <= 1'b0;
    end else if (!host_detected) begin
      det_cnt <= det_cnt + 16'd1;
      if (det_cnt == 16'(DETECT_CYC - 1)) begin
        host_detected <= 1'b1;
        host_is_usb <= !s_dm && !s_dp;
        lines_to_engine <= !s_dm && !s_dp;
        regulator_output_pin <= !s_dm && !s_dp;
      end
    end
  end
endmodule // omn_nav_frontend
`default_nettype wire

/* File: sim/omn_nav_frontend_assertions.sv */
// assertions on the front end's serial, wheel and host pins
// bound to omn_nav_frontend; one clock domain, async reset
`timescale 1ns/1ps
`default_nettype none
module omn_nav_frontend_assertions
  import omn_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic reset_n, // reset, active low
  input wire logic sensor_sleep_low, // sensor awake
  input wire logic sensor_reset, // sensor held
  input wire logic chip_select_low, // select
  input wire logic sclk, // serial clock
  input wire logic mosi, // data out
  input wire logic mosi_oe, // data enable
  input wire logic prog_done, // download done
  input wire logic [7:0] wheel_count, // wheel
  input wire logic dminus_in, // host line
  input wire logic dplus_in, // host line
  input wire logic host_is_usb, // usb host
  input wire logic host_detected, // detect done
  input wire logic lines_to_engine, // routing
  input wire logic regulator_output_pin // pull-up
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // pin level, ahead of the design's synchroniser, so aborts are excused early
  logic lost;
  assign lost = !sensor_sleep_low || sensor_reset;
  sequence s_rad_wait;
    (sclk && !chip_select_low)[*4];
  endsequence
  a_start_awake: assert property (
    $fell(chip_select_low) |-> !lost) else $error("frame began on a sleeping sensor");
  a_write_driven: assert property (
    $fell(chip_select_low) |-> mosi_oe) else $error("frame began without mosi");
  a_read_wait: assert property (disable iff (!reset_n || lost)
    $fell(mosi_oe) && !chip_select_low && prog_done |-> s_rad_wait)
    else $error("no pause before read data");
  a_data_setup: assert property (
    $rose(sclk) && mosi_oe && !chip_select_low |-> $stable(mosi)) else $error("mosi moved");
  a_release_idle: assert property (disable iff (!reset_n || lost)
    $rose(chip_select_low) |-> sclk && $past(sclk)) else $error("select rose mid-byte");
  a_wheel_step: assert property (
    $changed(wheel_count) |-> 8'(wheel_count - $past(wheel_count)) inside {8'h01, 8'hFF})
    else $error("wheel jumped");
  a_host_kind: assert property (
    $rose(host_detected) |-> host_is_usb == (!dminus_in && !dplus_in))
    else $error("wrong host kind");
  a_pullup_usb: assert property (
    $rose(host_detected) |-> regulator_output_pin == (!dminus_in && !dplus_in) &&
      lines_to_engine == regulator_output_pin && host_is_usb == regulator_output_pin)
    else $error("pull-up disagrees with host");
  a_pullup_early: assert property (
    !host_detected |-> !regulator_output_pin && !lines_to_engine)
    else $error("pull-up raised before detection");
endmodule // omn_nav_frontend_assertions
bind omn_nav_frontend omn_nav_frontend_assertions omn_nav_frontend_assertions_i (.clk,
  .reset_n, .sensor_sleep_low, .sensor_reset, .chip_select_low, .sclk, .mosi, .mosi_oe,
  .prog_done, .wheel_count, .dminus_in, .dplus_in, .host_is_usb, .host_detected,
  .lines_to_engine, .regulator_output_pin);
`default_nettype wire

/* File: sim/omn_sensor_model.sv */
// behavioural sensor on the four-wire link, for the bench only
// assumes mode 3: data taken on the rising, given on the falling clock
`timescale 1ns/1ps
`default_nettype none
module omn_sensor_model
  import omn_pkg::*;
(
  input wire logic chip_select_low, // select
  input wire logic sclk, // clock from controller
  input wire logic mosi, // data from controller
  input wire logic awake, // powered, out of reset
  input wire omn_motion_t reply, // burst contents
  output logic miso, // data to controller
  output logic [7:0] addr, // first byte of frame
  output logic [23:0] rx, // last written bytes
  output int n_rx // written bytes in frame
);
  logic [7:0] sh = 8'h00;
  logic [55:0] tx = 56'h0;
  int nbit = 0;
  initial {miso, addr, rx, n_rx} = 65'h0;
  always @(negedge chip_select_low) {nbit, n_rx} = 64'h0;
  always @(posedge sclk) begin
    if (!chip_select_low && awake) begin
      sh = {sh[6:0], mosi};
      nbit++;
      if (nbit == 8) {addr, tx} = {sh, reply};
      else if (nbit % 8 == 0 && addr[7]) {rx, n_rx} = {rx[15:0], sh, n_rx + 1};
    end
  end
  always @(negedge sclk) begin
    if (!chip_select_low && awake && nbit >= 8 && !addr[7]) begin
      miso = tx[55];
      tx = {tx[54:0], 1'b0};
    end
  end
  // a released line floats; the inverse keeps stale data from passing
  always @(posedge chip_select_low) miso = ~miso;
endmodule // omn_sensor_model
`default_nettype wire

/* File: sim/tb_top.sv */
// bench for the navigation front end: sensor model, wheel, buttons, host
// assumes hw/ on the include path; long counts shortened by parameters
`timescale 1ns/1ps
`default_nettype none
`include "omn_defines.svh"
module tb_top
  import omn_pkg::*;
;
  typedef struct packed {logic [1:0] ab; logic [7:0] wc;} omn_wheel_row_t;
  localparam logic [23:0] PROG = 24'hA53C96;
  localparam omn_motion_t MROWS [2] = '{56'h8105FB40012C7F, 56'h00807F00FF0001};
  localparam omn_wheel_row_t WROWS [7] = '{'{2'h1, 8'h01}, '{2'h3, 8'h02}, '{2'h2, 8'h03},
    '{2'h0, 8'h04}, '{2'h2, 8'h03}, '{2'h3, 8'h02}, '{2'h0, 8'h02}};
  localparam logic [2:0] BPATS [3] = '{3'h2, 3'h5, 3'h7};
  logic clk = 1'b0;
  logic reset_n, sensor_sleep_low, sensor_reset, chip_select_low, sclk, mosi, mosi_oe, miso;
  logic prog_wr_en, prog_done, motion_valid, wheel_a, wheel_b, left_n, wheel_btn_n, right_n;
  logic dminus_in, dplus_in, host_is_usb, host_detected, lines_to_engine, regulator_output_pin;
  logic [10:0] prog_wr_addr;
  logic [7:0] prog_wr_data, wheel_count, rx_addr;
  logic [23:0] rx_data;
  logic [2:0] prev;
  omn_motion_t motion, reply;
  omn_buttons_t buttons;
  int mismatches = 0, n_compared = 0, cycles = 0, n_rx, i;
  omn_nav_frontend #(.DEBOUNCE_CYC(20), .RAD_CYC(4), .POLL_CYC(50), .DETECT_CYC(10),
    .PROG_LEN(3)) omn_nav_frontend_i (.clk, .reset_n, .sensor_sleep_low, .sensor_reset,
    .chip_select_low, .sclk, .mosi, .mosi_oe, .miso, .prog_wr_en, .prog_wr_addr, .prog_wr_data,
    .prog_done, .motion, .motion_valid, .wheel_count, .wheel_a, .wheel_b, .left_n,
    .wheel_btn_n, .right_n, .buttons, .dminus_in, .dplus_in, .host_is_usb, .host_detected,
    .lines_to_engine, .regulator_output_pin);
  omn_sensor_model omn_sensor_model_i (.chip_select_low, .sclk, .mosi, .miso, .reply,
    .awake(sensor_sleep_low && !sensor_reset), .addr(rx_addr), .rx(rx_data), .n_rx);
  always #20 clk = ~clk;
  task automatic chk(string what, logic [55:0] exp, logic [55:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_on(string what, ref logic sig, input logic lvl);
    int k = 0;
    do @(negedge clk); while (sig !== lvl && ++k < 2000);
    chk(what, lvl, sig);
  endtask
  task automatic check_download();
    wait_on("program done", prog_done, 1'b1);
    chk("download address", `OMN_ADDR_PROG_BURST | `OMN_WRITE_BIT, rx_addr);
    chk("download bytes", {8'h03, PROG}, {8'(n_rx), rx_data});
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end
  initial begin
    {reset_n, sensor_sleep_low, sensor_reset, prog_wr_en, wheel_a, wheel_b} = 6'h00;
    {dminus_in, dplus_in, prog_wr_addr, prog_wr_data} = 21'h0;
    {left_n, wheel_btn_n, right_n} = 3'h7;
    reply = 56'h0;
    prev = 3'h0;
    repeat (12) @(posedge clk);
    chk("reset outputs", 4'hC, {chip_select_low, sclk, mosi_oe, prog_done});
    reset_n <= 1'b1;
    // the store is filled while the sensor sleeps, before any download may start
    for (i = 0; i < 3; i++) begin
      @(posedge clk);
      prog_wr_en <= 1'b1;
      prog_wr_addr <= 11'(i);
      prog_wr_data <= PROG[23 - 8 * i -: 8];
    end
    @(posedge clk);
    prog_wr_en <= 1'b0;
    wait_on("host detect", host_detected, 1'b1);
    chk("usb host", 3'h7, {host_is_usb, lines_to_engine, regulator_output_pin});
    chk("asleep select", 1'b1, chip_select_low);
    @(posedge clk);
    sensor_sleep_low <= 1'b1;
    check_download();
    for (i = 0; i < 2; i++) begin
      wait_on("motion start", chip_select_low, 1'b0);
      reply = MROWS[i];
      wait_on("motion done", motion_valid, 1'b1);
      chk("motion", MROWS[i], motion);
      wait_on("frame end", chip_select_low, 1'b1);
    end
    chk("motion address", `OMN_ADDR_MOTION_BURST, rx_addr);
    for (i = 0; i < 7; i++) begin
      @(posedge clk);
      {wheel_a, wheel_b} <= WROWS[i].ab;
      repeat (8) @(negedge clk);
      chk("wheel", WROWS[i].wc, wheel_count);
    end
    @(posedge clk);
    left_n <= 1'b0;
    repeat (10) @(posedge clk);
    left_n <= 1'b1;
    repeat (30) @(negedge clk);
    chk("bounce", 3'h0, buttons);
    for (i = 0; i < 3; i++) begin
      @(posedge clk);
      {left_n, wheel_btn_n, right_n} <= BPATS[i];
      repeat (12) @(negedge clk);
      chk("button early", prev, buttons);
      repeat (24) @(negedge clk);
      prev = ~BPATS[i];
      chk("button", prev, buttons);
    end
    wait_on("poll", chip_select_low, 1'b0);
    repeat (30) @(posedge clk);
    sensor_reset <= 1'b1;
    repeat (8) @(negedge clk);
    chk("abort", 2'h2, {chip_select_low, prog_done});
    @(posedge clk);
    sensor_reset <= 1'b0;
    check_download();
    @(posedge clk);
    reset_n <= 1'b0;
    {wheel_a, wheel_b} <= 2'h1;
    dminus_in <= 1'b1;
    dplus_in <= 1'b1;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    wait_on("host detect", host_detected, 1'b1);
    chk("ps2 host", 3'h0, {host_is_usb, lines_to_engine, regulator_output_pin});
    chk("wheel after reset", 8'h00, wheel_count);
    check_download();
    conclude();
  end
endmodule // tb_top
`default_nettype wire
